// file: inc/pssr_pkg.sv
// shared constants and types for the periodic complete-split response block
package pssr_pkg;

    // ------------------------------------------------------------
    // microframe timer
    // ------------------------------------------------------------
    localparam int          UFRAMES_PER_FRAME = 8;      // microframes per 1 ms frame
    localparam int          UF_W              = 3;      // microframe label width
    localparam logic [2:0]  UF_FIRST          = 3'h0;   // label of the zeroth microframe
    localparam logic [2:0]  UF_LAST           = 3'h7;   // label of the last microframe
    localparam int          FRNUM_W           = 11;     // frame number carried by SOF
    localparam logic [10:0] FRNUM_RST         = 11'h000; // frame number before first SOF

    // ------------------------------------------------------------
    // downstream data handling
    // ------------------------------------------------------------
    localparam int          BYTE_W            = 8;      // downstream byte width
    localparam int          CNT_W             = 11;     // room for 1023 data plus crc
    localparam logic [10:0] CNT_RST           = 11'h000; // byte count after reset
    localparam logic [10:0] CNT_MAX           = 11'h7ff; // byte count saturation point
    localparam logic [10:0] MDATA_MIN         = 11'h003; // fewest bytes that give partial data
    localparam logic [1:0]  HOLD_DEPTH        = 2'h2;   // bytes held back as possible crc
    localparam logic [1:0]  HOLD_RST          = 2'h0;   // hold count after reset
    localparam logic [7:0]  BYTE_RST          = 8'h00;  // byte register reset value
    localparam int          FIFO_DEPTH        = 8;      // returned data buffer depth

    // ------------------------------------------------------------
    // complete-split answers
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RSP_DATA0 = 3'h0,   // last data, even pid
        RSP_DATA1 = 3'h1,   // last data, odd pid
        RSP_MDATA = 3'h2,   // partial data, more follows
        RSP_ERR   = 3'h3,   // downstream crc failed
        RSP_NYET  = 3'h4    // nothing yet
    } pssr_rsp_e;

    // ------------------------------------------------------------
    // downstream transaction tracking
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DS_IDLE = 2'h0,     // no transaction running
        DS_RECV = 2'h1,     // data packet arriving
        DS_OK   = 2'h2,     // finished with good crc
        DS_BAD  = 2'h3      // finished with bad crc
    } pssr_ds_e;

endpackage

// file: hw/pssr_tt_resp.sv
// periodic complete-split response logic with its returned data buffer
`timescale 1ns/1ps

// ------------------------------------------------------------
// ------------------------------------------------------------

// ------------------------------------------------------------
// data buffer, flip-flop storage, registered ready
// ------------------------------------------------------------
module pssr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ZERO = '0;
    localparam logic [AW-1:0] PTR_LAST = (AW)'(DEPTH-1);

    logic [WIDTH-1:0] mem_q [DEPTH];   // storage entries
    logic [AW-1:0]    wr_q;            // write index
    logic [AW-1:0]    rd_q;            // read index
    logic [AW:0]      cnt_q;           // words held
    logic [AW:0]      cnt_d;           // next word count
    logic             ready_q;         // room for one more word
    wire              push = in_valid & ready_q;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = ready_q;
    assign out_valid = (cnt_q != CNT_ZERO);
    assign out_data  = mem_q[rd_q];
    // flush empties; push and pop may share a cycle
    assign cnt_d = flush ? CNT_ZERO
                 : (cnt_q + (AW+1)'(push) - (AW+1)'(pop));

    // pointers and count; ready is registered so that it is a clean flop output
    always_ff @(posedge clk)
    begin
        if (srst | flush)
        begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= CNT_ZERO;
            ready_q <= 1'b1;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
            cnt_q   <= cnt_d;
            ready_q <= (cnt_d != CNT_FULL);
        end
    end

    // storage, one write port per entry
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_ent
            always_ff @(posedge clk)
            begin
                if (srst)
                    mem_q[gi] <= '0;
                else if (push && wr_q == (AW)'(gi))
                    mem_q[gi] <= in_data;
            end
        end
    endgenerate
endmodule // pssr_fifo

// ------------------------------------------------------------
// complete-split response top
// ------------------------------------------------------------
module pssr_tt_resp
    import pssr_pkg::*;
#(
    parameter int DEPTH = pssr_pkg::FIFO_DEPTH
)
(
    input  wire logic                        MCLK,
    input  wire logic                        SRST,
    input  wire logic                        HS_SOF,
    input  wire logic [pssr_pkg::FRNUM_W-1:0] HS_FRAME_NUM,
    output logic [pssr_pkg::UF_W-1:0]        UFRAME,
    input  wire logic                        DS_START,
    input  wire logic                        DS_ISO,
    input  wire logic                        DS_BYTE_VALID,
    input  wire logic [pssr_pkg::BYTE_W-1:0] DS_BYTE,
    output logic                             DS_READY,
    input  wire logic                        DS_END,
    input  wire logic                        DS_CRC_OK,
    input  wire logic                        DS_PID1,
    input  wire logic                        CS_REQ,
    output logic                             RSP_VALID,
    output pssr_pkg::pssr_rsp_e              RSP_PID,
    output logic                             RET_VALID,
    input  wire logic                        RET_READY,
    output logic [pssr_pkg::BYTE_W-1:0]      RET_DATA
);
    import pssr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [UF_W-1:0]    uf_q;          // current microframe label
    logic [FRNUM_W-1:0] frnum_q;       // frame number of the last SOF
    pssr_ds_e           ds_q;          // downstream transaction state
    pssr_ds_e           ds_d;
    logic               iso_q;         // running transaction is isochronous
    logic               pid1_q;        // downstream data pid was odd
    logic [CNT_W-1:0]   cnt_q;         // data bytes received so far
    logic [1:0]         hold_n_q;      // bytes held back
    logic [BYTE_W-1:0]  hold0_q;       // oldest held byte
    logic [BYTE_W-1:0]  hold1_q;       // newest held byte
    logic               ent_q;         // complete-split pipeline entry exists
    pssr_rsp_e          ent_pid_q;     // answer stored in the entry
    pssr_rsp_e          ent_pid_d;
    logic               rsp_valid_q;   // answer strobe
    pssr_rsp_e          rsp_pid_q;     // answer code
    logic               ret_valid_q;   // output data stage valid
    logic [BYTE_W-1:0]  ret_data_q;    // output data stage byte

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire new_frame = HS_SOF & (HS_FRAME_NUM != frnum_q);
    wire fifo_ready;                    // room in the data buffer
    wire fifo_out_valid;
    wire [BYTE_W-1:0] fifo_out_data;
    wire take_byte  = DS_BYTE_VALID & fifo_ready & (ds_q == DS_RECV);
    wire push_old   = take_byte & (hold_n_q == HOLD_DEPTH);
    wire bad_end    = DS_END & ~DS_CRC_OK & (ds_q == DS_RECV);
    wire good_end   = DS_END & DS_CRC_OK & (ds_q == DS_RECV);
    wire stage_free = ~ret_valid_q | RET_READY;
    wire fifo_pop   = fifo_out_valid & stage_free & ~bad_end;
    wire last_pid   = (~iso_q & pid1_q);   // iso always even
    wire mid_data   = (cnt_q >= MDATA_MIN);

    // answer chosen at the boundary from the state of the microframe just ended
    assign ent_pid_d = (ds_q == DS_OK)  ? (last_pid ? RSP_DATA1 : RSP_DATA0)
                     : (ds_q == DS_BAD) ? RSP_ERR
                     : mid_data         ? RSP_MDATA
                     :                    RSP_NYET;

    // end events win over the boundary so that a finish on the SOF cycle is kept
    assign ds_d = DS_START ? DS_RECV
                : good_end ? DS_OK
                : bad_end  ? DS_BAD
                : (HS_SOF && (ds_q == DS_OK || ds_q == DS_BAD)) ? DS_IDLE
                : ds_q;

    assign UFRAME    = uf_q;
    assign RSP_VALID = rsp_valid_q;
    assign RSP_PID   = rsp_pid_q;
    assign RET_VALID = ret_valid_q;
    assign RET_DATA  = ret_data_q;

    // ------------------------------------------------------------
    // microframe timer
    // ------------------------------------------------------------
    // realigns on each frame number change; holds at Y7 while SOFs repeat the same frame number
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            uf_q    <= UF_FIRST;
            frnum_q <= FRNUM_RST;
        end
        else if (HS_SOF)
        begin
            frnum_q <= HS_FRAME_NUM;
            if (new_frame)
                uf_q <= UF_FIRST;
            else if (uf_q != UF_LAST)
                uf_q <= uf_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // downstream tracking and crc holdback
    // ------------------------------------------------------------
    // the two newest bytes never reach the buffer: they may be the crc
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ds_q     <= DS_IDLE;
            iso_q    <= 1'b0;
            pid1_q   <= 1'b0;
            cnt_q    <= CNT_RST;
            hold_n_q <= HOLD_RST;
            hold0_q  <= BYTE_RST;
            hold1_q  <= BYTE_RST;
        end
        else
        begin
            ds_q <= ds_d;
            if (DS_START)
            begin
                iso_q    <= DS_ISO;
                cnt_q    <= CNT_RST;
                hold_n_q <= HOLD_RST;
            end
            else if (take_byte)
            begin
                if (cnt_q != CNT_MAX)
                    cnt_q <= cnt_q + 1'b1;
                hold0_q <= (hold_n_q == HOLD_RST) ? DS_BYTE : hold1_q;
                hold1_q <= DS_BYTE;
                if (hold_n_q != HOLD_DEPTH)
                    hold_n_q <= hold_n_q + 1'b1;
            end
            if (DS_END)
                pid1_q <= DS_PID1;
        end
    end

    // ------------------------------------------------------------
    // complete-split pipeline entry and answer
    // ------------------------------------------------------------
    // entry made at each boundary with something running; one answer consumes it
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ent_q       <= 1'b0;
            ent_pid_q   <= RSP_NYET;
            rsp_valid_q <= 1'b0;
            rsp_pid_q   <= RSP_NYET;
        end
        else
        begin
            rsp_valid_q <= CS_REQ;
            if (CS_REQ)
                rsp_pid_q <= ent_q ? ent_pid_q : RSP_NYET;
            if (HS_SOF)
            begin
                ent_q     <= (ds_q != DS_IDLE);
                ent_pid_q <= ent_pid_d;
            end
            else if (CS_REQ)
                ent_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // returned data output stage
    // ------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ret_valid_q <= 1'b0;
            ret_data_q  <= BYTE_RST;
        end
        else if (stage_free)
        begin
            ret_valid_q <= fifo_pop;
            if (fifo_pop)
                ret_data_q <= fifo_out_data;
        end
    end

    // bad crc flushes whatever is still buffered
    pssr_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_fifo
    (
        .clk       (MCLK),
        .srst      (SRST),
        .flush     (bad_end),
        .in_valid  (push_old),
        .in_ready  (fifo_ready),
        .in_data   (hold0_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );
    assign DS_READY = fifo_ready;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_y0_new_frame: assert property (@(posedge MCLK) disable iff (SRST)
        new_frame |=> (uf_q == UF_FIRST)) else $error("no Y0 on new frame");
    a_y_advance: assert property (@(posedge MCLK) disable iff (SRST)
        (HS_SOF && !new_frame && uf_q != UF_LAST) |=> (uf_q == $past(uf_q) + 3'h1))
        else $error("microframe did not advance");
    a_y_steady: assert property (@(posedge MCLK) disable iff (SRST)
        !HS_SOF |=> $stable(uf_q)) else $error("microframe moved without sof");
    a_good_pid: assert property (@(posedge MCLK) disable iff (SRST)
        (HS_SOF && ds_q == DS_OK) |=> ent_q && (ent_pid_q == ($past(last_pid) ?
        RSP_DATA1 : RSP_DATA0))) else $error("wrong data pid");
    a_bad_crc: assert property (@(posedge MCLK) disable iff (SRST)
        bad_end |=> !fifo_out_valid ##0 (ds_q == DS_BAD)) else $error("bad crc kept data");
    a_mdata_mid: assert property (@(posedge MCLK) disable iff (SRST)
        (HS_SOF && ds_q == DS_RECV && cnt_q > 11'h002) |=> (ent_pid_q == RSP_MDATA))
        else $error("missing mdata");
    a_nyet_short: assert property (@(posedge MCLK) disable iff (SRST)
        (HS_SOF && ds_q == DS_RECV && cnt_q < 11'h003) |=> (ent_pid_q == RSP_NYET))
        else $error("short data not nyet");
    a_nyet_empty: assert property (@(posedge MCLK) disable iff (SRST)
        (CS_REQ && !ent_q) |=> (RSP_VALID && RSP_PID == RSP_NYET))
        else $error("no entry but not nyet");
endmodule // pssr_tt_resp

// file: testbench/pssr_host_model.sv
// host-side model: microframe starts and complete-splits toward the translator
`timescale 1ns/1ps
module pssr_host_model
(
    input  wire logic                    mclk,
    output logic                         hs_sof,
    output logic [pssr_pkg::FRNUM_W-1:0] hs_frame_num,
    output logic                         cs_req,
    input  wire logic                    rsp_valid,
    input  wire logic [2:0]              rsp_pid
);
    import pssr_pkg::*;

    // no start-split or iso OUT traffic leaves this model
    // one transaction at a time, so complete-split order always matches
    // the modelled link never corrupts a packet, so no retry is ever owed
    logic [UF_W-1:0] uf_q;      // host's own microframe label
    logic            cs_sent_q; // a complete-split already went out this microframe

    initial
    begin
        hs_sof       = 1'b0;
        hs_frame_num = FRNUM_RST;
        cs_req       = 1'b0;
        uf_q         = UF_LAST; // first start opens a fresh frame
        cs_sent_q    = 1'b0;
    end

    // one microframe start; every eighth carries a new frame number
    task automatic start_uframe();
        @(posedge mclk);
        #2;
        if (uf_q == UF_LAST)
        begin
            hs_frame_num = hs_frame_num + 11'h001;
            uf_q         = UF_FIRST;
        end
        else
            uf_q = uf_q + 3'h1;
        cs_sent_q = 1'b0;
        hs_sof    = 1'b1;
        @(posedge mclk);
        #2;
        hs_sof = 1'b0;
    endtask

    // one complete-split; the answer strobe is taken one cycle after the request
    task automatic complete_split(output pssr_rsp_e pid, output logic seen);
        pid  = RSP_NYET;
        seen = 1'b0;
        if (!cs_sent_q) // never two in one microframe
        begin
            @(posedge mclk);
            #2;
            cs_req = 1'b1; // only inside the current microframe
            @(posedge mclk);
            #2;
            cs_req    = 1'b0;
            seen      = rsp_valid;
            pid       = pssr_rsp_e'(rsp_pid);
            cs_sent_q = 1'b1;
        end
    endtask
endmodule // pssr_host_model

// file: testbench/tb_top.sv
// self-checking bench for the periodic complete-split response block
`timescale 1ns/1ps
module tb_top;
    import pssr_pkg::*;

    logic              MCLK, SRST, HS_SOF, CS_REQ, RSP_VALID;  // clock, reset, host side
    logic              DS_START, DS_ISO, DS_BYTE_VALID, DS_READY; // downstream side
    logic              DS_END, DS_CRC_OK, DS_PID1;             // downstream packet end
    logic              RET_VALID, RET_READY;                   // returned data handshake
    logic [7:0]        DS_BYTE, RET_DATA;                      // byte lanes
    logic [2:0]        UFRAME;                                 // microframe label
    logic [10:0]       HS_FRAME_NUM;                           // frame number
    pssr_rsp_e         RSP_PID;                                // answer code
    logic [7:0]        ret_q[$];                               // bytes handed back
    int                n_mismatch = 0;
    int                n_compared = 0;

    pssr_tt_resp #(.DEPTH(FIFO_DEPTH)) dut (.MCLK(MCLK), .SRST(SRST), .HS_SOF(HS_SOF),
        .HS_FRAME_NUM(HS_FRAME_NUM), .UFRAME(UFRAME), .DS_START(DS_START), .DS_ISO(DS_ISO),
        .DS_BYTE_VALID(DS_BYTE_VALID), .DS_BYTE(DS_BYTE), .DS_READY(DS_READY),
        .DS_END(DS_END), .DS_CRC_OK(DS_CRC_OK), .DS_PID1(DS_PID1), .CS_REQ(CS_REQ),
        .RSP_VALID(RSP_VALID), .RSP_PID(RSP_PID), .RET_VALID(RET_VALID),
        .RET_READY(RET_READY), .RET_DATA(RET_DATA));
    pssr_host_model host (.mclk(MCLK), .hs_sof(HS_SOF), .hs_frame_num(HS_FRAME_NUM),
        .cs_req(CS_REQ), .rsp_valid(RSP_VALID), .rsp_pid(RSP_PID));

    always #12.5 MCLK = ~MCLK;

    // collect every returned byte at the edge that takes it
    always @(posedge MCLK)
        if (RET_VALID === 1'b1 && RET_READY === 1'b1)
            ret_q.push_back(RET_DATA);

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge MCLK);
        #2;
    endtask

    // valid stays up across bytes so it is never driven twice in one step
    task automatic send_bytes(input int n, input logic [7:0] base);
        logic taken;
        DS_BYTE_VALID = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            DS_BYTE = base + 8'(i);
            taken = 1'b0;
            for (int k = 0; k < 40 && !taken; k++)
            begin
                @(posedge MCLK);
                taken = (DS_READY === 1'b1);
            end
            #2;
            if (!taken)
            begin
                n_mismatch++;
                complete_run();
            end
        end
        DS_BYTE_VALID = 1'b0;
    endtask

    task automatic begin_pkt(input logic iso);
        DS_START = 1'b1;
        DS_ISO   = iso;
        tick();
        DS_START = 1'b0;
    endtask

    task automatic end_pkt(input logic ok, input logic pid1);
        DS_END    = 1'b1;
        DS_CRC_OK = ok;
        DS_PID1   = pid1;
        tick();
        DS_END = 1'b0;
    endtask

    task automatic cs_expect(input pssr_rsp_e exp);
        pssr_rsp_e pid;
        logic      seen;
        host.complete_split(pid, seen);
        check(16'(seen), 16'h0001);
        check(16'(pid), 16'(exp));
    endtask

    // short settle window so a stray held-back byte would show up
    task automatic ret_expect(input int n, input logic [7:0] base);
        for (int k = 0; k < 40 && ret_q.size() < n; k++)
            tick();
        repeat (4) tick();
        check(16'(ret_q.size()), 16'(n));
        for (int i = 0; i < n && i < ret_q.size(); i++)
            check({8'h00, ret_q[i]}, {8'h00, base + 8'(i)});
        ret_q.delete();
    endtask

    task automatic t_reset();
        tick();
        check(16'(UFRAME), 16'h0000);
        check(16'(RSP_VALID), 16'h0000);
        check(16'(RSP_PID), 16'(RSP_NYET));
        check(16'(RET_VALID), 16'h0000);
        check(16'(DS_READY), 16'h0001);
        cs_expect(RSP_NYET);
        $display("reset test done");
    endtask

    task automatic t_frame();
        for (int i = 0; i < 9; i++)
        begin
            host.start_uframe();
            check(16'(UFRAME), 16'(i % 8));
        end
        cs_expect(RSP_NYET);
        $display("frame timer test done");
    endtask

    // iso answers even pid whatever came downstream; interrupt echoes it
    task automatic t_complete();
        for (int m = 0; m < 4; m++)
        begin
            begin_pkt(m < 2);
            send_bytes(5, 8'h10);
            end_pkt(1'b1, m[0]);
            host.start_uframe();
            cs_expect((m == 3) ? RSP_DATA1 : RSP_DATA0);
            ret_expect(3, 8'h10);
        end
        $display("good crc test done");
    endtask

    // stalled sink: the flush must meet a non-empty buffer; the staged byte is not recalled
    task automatic t_bad();
        RET_READY = 1'b0;
        begin_pkt(1'b0);
        send_bytes(5, 8'h50);
        end_pkt(1'b0, 1'b1);
        RET_READY = 1'b1;
        host.start_uframe();
        cs_expect(RSP_ERR);
        ret_expect(1, 8'h50);
        $display("bad crc test done");
    endtask

    // three bytes in flight is the smallest partial answer
    task automatic t_partial();
        begin_pkt(1'b1);
        send_bytes(3, 8'h20);
        host.start_uframe();
        cs_expect(RSP_MDATA);
        ret_expect(1, 8'h20);
        send_bytes(2, 8'h23);
        end_pkt(1'b1, 1'b0);
        host.start_uframe();
        cs_expect(RSP_DATA0);
        ret_expect(2, 8'h21);
        $display("partial data test done");
    endtask

    task automatic t_nyet();
        begin_pkt(1'b0);
        send_bytes(2, 8'h30);
        host.start_uframe();
        cs_expect(RSP_NYET);
        end_pkt(1'b1, 1'b0);
        host.start_uframe();
        cs_expect(RSP_DATA0);
        ret_expect(0, 8'h30);
        $display("nyet test done");
    endtask

    // sink stalls until the buffer refuses, then drains in order
    task automatic t_stall();
        RET_READY = 1'b0;
        begin_pkt(1'b1);
        fork
            send_bytes(14, 8'h40);
        join_none
        for (int k = 0; k < 60 && DS_READY !== 1'b0; k++)
            tick();
        check(16'(DS_READY), 16'h0000);
        repeat (5) tick();
        check(16'(ret_q.size()), 16'h0000);
        RET_READY = 1'b1;
        wait fork;
        end_pkt(1'b1, 1'b0);
        host.start_uframe();
        cs_expect(RSP_DATA0);
        ret_expect(12, 8'h40);
        $display("stall test done");
    endtask

    initial
    begin
        MCLK          = 1'b0;
        SRST          = 1'b1;
        DS_START      = 1'b0;
        DS_ISO        = 1'b0;
        DS_BYTE_VALID = 1'b0;
        DS_BYTE       = 8'h00;
        DS_END        = 1'b0;
        DS_CRC_OK     = 1'b0;
        DS_PID1       = 1'b0;
        RET_READY     = 1'b1;
        repeat (3) @(posedge MCLK);
        #2;
        SRST = 1'b0;
        t_reset();
        t_frame();
        t_complete();
        t_bad();
        t_partial();
        t_nyet();
        t_stall();
        complete_run();
    end
endmodule // tb_top
